/* src/irq_accept.sv */
// interrupt acceptance logic: enable flags, arbitration, redirect address
module irq_accept
	import irq_accept_pkg::*;
(
	// clock and reset
	input  wire logic                  i_clk,
	input  wire logic                  i_rst_n,
	// request lines
	input  wire logic [7:0]            i_nmi_src,
	input  wire logic [2:0]            i_nmi_sel,
	input  wire logic                  i_irq_n,
	// instruction sequencer
	input  wire logic                  i_boundary,
	input  wire addr_t                 i_next_pc,
	input  wire logic                  i_enable_irq_instruction,
	input  wire logic                  i_disable_irq_instruction,
	input  wire logic                  i_restore_enable,
	input  wire logic                  i_return_done,
	input  wire irq_mode_e             i_irq_mode,
	input  wire byte_t                 i_vector_page,
	// controller side
	output logic                       o_irq_acknowledge_n,
	input  wire byte_t                 i_vector_low,
	// table memory read
	output logic                       o_mem_rd,
	output addr_t                      o_mem_addr,
	input  wire logic                  i_mem_ack,
	input  wire byte_t                 i_mem_data,
	// redirect to sequencer
	output logic                       o_redirect,
	output addr_t                      o_redirect_addr,
	output logic                       o_discard_fetch,
	output logic                       o_resume,
	output addr_t                      o_resume_addr,
	output logic                       o_busy,
	// flag view
	output logic                       o_primary_enable_flag,
	output logic                       o_shadow_enable_flag
);
	import irq_accept_pkg::*;
	`include "irq_accept_params.svh"

	typedef enum logic [1:0] {S_RUN, S_ACK, S_FETCH} acc_e;

	acc_e  st_r;
	logic  primary_enable_flag_r;
	logic  shadow_enable_flag_r;
	logic  ei_hold_r;
	logic  redirect_r;
	addr_t redirect_addr_r;
	logic  discard_r;
	logic  resume_r;
	addr_t saved_pc_r;
	logic  fetch_req_r;
	addr_t fetch_ptr_r;

	irq_vec_if vec ();

	irq_vec_fetch u_fetch (
		.i_clk      (i_clk),
		.i_rst_n    (i_rst_n),
		.vec        (vec.fetch),
		.o_mem_rd   (o_mem_rd),
		.o_mem_addr (o_mem_addr),
		.i_mem_ack  (i_mem_ack),
		.i_mem_data (i_mem_data)
	);

	assign vec.req = fetch_req_r;
	assign vec.ptr = fetch_ptr_r;

	// =========================================================
	// request decode
	// =========================================================
	wire   nmi_line  = i_nmi_src[i_nmi_sel];
	logic  nmi_prev_r;
	wire   nmi_edge  = nmi_line && !nmi_prev_r;
	logic  nmi_pend_r;
	wire   nmi_req   = nmi_pend_r || nmi_edge;
	wire   run_bound = (st_r == S_RUN) && i_boundary;
	wire   take_nmi  = run_bound && nmi_req;
	wire   irq_ok    = primary_enable_flag_r && !ei_hold_r;
	wire   take_irq  = run_bound && !nmi_req && !i_irq_n && irq_ok;
	// table pointer: page register high, controller byte low
	wire   addr_t tbl_ptr = {i_vector_page, i_vector_low & `VEC_LSB_MASK};
	wire   addr_t rst_vec = {`BYTE_ZERO, (i_vector_low & `MODE0_RESTART_LOW)};

	assign o_irq_acknowledge_n   = !(st_r == S_ACK);
	assign o_redirect            = redirect_r;
	assign o_redirect_addr       = redirect_addr_r;
	assign o_discard_fetch       = discard_r;
	assign o_resume              = resume_r;
	assign o_resume_addr         = saved_pc_r;
	assign o_busy                = (st_r != S_RUN);
	assign o_primary_enable_flag = primary_enable_flag_r;
	assign o_shadow_enable_flag  = shadow_enable_flag_r;

	// =========================================================
	// non-maskable pending latch
	// =========================================================
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			nmi_prev_r <= 1'b0;
			nmi_pend_r <= 1'b0;
		end else begin
			nmi_prev_r <= nmi_line;
			if (nmi_edge && !take_nmi)
				nmi_pend_r <= 1'b1;
			else if (take_nmi)
				nmi_pend_r <= 1'b0;
		end
	end

	// =========================================================
	// enable flags
	// =========================================================
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			primary_enable_flag_r <= 1'b0;
			shadow_enable_flag_r  <= 1'b0;
			ei_hold_r             <= 1'b0;
		end else begin
			if (take_nmi) begin
				primary_enable_flag_r <= 1'b0;
			end else if (take_irq) begin
				primary_enable_flag_r <= 1'b0;
				shadow_enable_flag_r  <= 1'b0;
			end else if (i_enable_irq_instruction) begin
				primary_enable_flag_r <= 1'b1;
				shadow_enable_flag_r  <= 1'b1;
			end else if (i_disable_irq_instruction) begin
				primary_enable_flag_r <= 1'b0;
				shadow_enable_flag_r  <= 1'b0;
			end else if (i_restore_enable) begin
				primary_enable_flag_r <= shadow_enable_flag_r;
			end
			// hold past the first boundary after the enable: the one ending it, or the next one when the enable came at a boundary
			if (i_enable_irq_instruction)
				ei_hold_r <= 1'b1;
			else if (i_boundary)
				ei_hold_r <= 1'b0;
		end
	end

	// =========================================================
	// acceptance sequence
	// =========================================================
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st_r            <= S_RUN;
			redirect_r      <= 1'b0;
			redirect_addr_r <= `ADDR_ZERO;
			discard_r       <= 1'b0;
			resume_r        <= 1'b0;
			saved_pc_r      <= `ADDR_ZERO;
			fetch_req_r     <= 1'b0;
			fetch_ptr_r     <= `ADDR_ZERO;
		end else begin
			redirect_r  <= 1'b0;
			discard_r   <= 1'b0;
			fetch_req_r <= 1'b0;
			resume_r    <= i_return_done;
			unique case (st_r)
				S_RUN: begin
					if (take_nmi) begin
						saved_pc_r      <= i_next_pc;
						discard_r       <= 1'b1;
						redirect_r      <= 1'b1;
						redirect_addr_r <= `NMI_RESTART_ADDR;
					end else if (take_irq) begin
						saved_pc_r <= i_next_pc;
						st_r       <= S_ACK;
					end
				end
				S_ACK: begin
					unique case (i_irq_mode)
						IRQ_MODE_1: begin
							redirect_r      <= 1'b1;
							redirect_addr_r <= `MODE1_RESTART;
							st_r            <= S_RUN;
						end
						IRQ_MODE_2: begin
							fetch_req_r <= 1'b1;
							fetch_ptr_r <= tbl_ptr;
							st_r        <= S_FETCH;
						end
						default: begin
							redirect_r      <= 1'b1;
							redirect_addr_r <= rst_vec;
							st_r            <= S_RUN;
						end
					endcase
				end
				S_FETCH: begin
					if (vec.done) begin
						redirect_r      <= 1'b1;
						redirect_addr_r <= vec.target;
						st_r            <= S_RUN;
					end
				end
				default: st_r <= S_RUN;
			endcase
		end
	end
endmodule // irq_accept

/* src/irq_accept_params.svh */
// constants and rule summary for the interrupt acceptance logic
// Operation
// - A non-maskable request is always taken, whatever the enable flags hold.
// - Taking a non-maskable request drops the fetched instruction and restarts at 0x0066.
// - The non-maskable source is picked from several bus lines by a select input.
// - The return address saved at acceptance is handed back when service ends.
// - Three maskable modes; the table mode joins the page register and vector byte.
// - The maskable line is honoured only while the primary enable flag is set.
// - Reset clears both enable flags.
// - The enable instruction sets both flags and the disable instruction clears both.
// - After the enable instruction one more instruction completes before a maskable take; with the enable at its own boundary the hold lets two complete.
// - Taking a maskable request clears both enable flags.
// - Taking a non-maskable request clears only the primary flag, keeping the shadow.
// - Instructions can read the shadow flag or copy it into the primary flag.
// - An accepted maskable request drives the acknowledge signal to the controllers.
`ifndef IRQ_ACCEPT_PARAMS_SVH
`define IRQ_ACCEPT_PARAMS_SVH

`define NMI_RESTART_ADDR  16'h0066
`define MODE0_RESTART_LOW 8'h38
`define MODE1_RESTART     16'h0038
`define NMI_SRC_COUNT     8
`define NMI_SEL_W         3
`define ADDR_W            16
`define BYTE_W            8
`define ADDR_ZERO         16'h0000
`define BYTE_ZERO         8'h00
`define VEC_LSB_MASK      8'hfe
`define ADDR_ONE          16'h0001

`endif

/* src/irq_accept_pkg.sv */
// types shared by the interrupt acceptance logic
package irq_accept_pkg;
	typedef enum logic [1:0] {
		IRQ_MODE_0,
		IRQ_MODE_1,
		IRQ_MODE_2,
		IRQ_MODE_RSVD
	} irq_mode_e;

	typedef logic [15:0] addr_t;
	typedef logic [7:0]  byte_t;
endpackage

/* src/irq_vec_if.sv */
// vector fetch request/answer between acceptance logic and table fetch
interface irq_vec_if;
	import irq_accept_pkg::*;
	logic  req;
	addr_t ptr;
	logic  done;
	addr_t target;

	modport ctrl  (output req, output ptr, input done, input target);
	modport fetch (input req, input ptr, output done, output target);
endinterface

/* src/irq_vec_fetch.sv */
// two-byte table read that turns a vector pointer into a routine address
module irq_vec_fetch
	import irq_accept_pkg::*;
(
	// clock and reset
	input  wire logic      i_clk,
	input  wire logic      i_rst_n,
	// control side
	irq_vec_if.fetch       vec,
	// memory read port
	output logic           o_mem_rd,
	output addr_t          o_mem_addr,
	input  wire logic      i_mem_ack,
	input  wire byte_t     i_mem_data
);
	`include "irq_accept_params.svh"

	typedef enum logic [1:0] {F_IDLE, F_LOW, F_HIGH, F_DONE} fetch_e;

	fetch_e st_r;
	byte_t  low_r;
	addr_t  addr_r;
	addr_t  target_r;

	assign o_mem_rd   = (st_r == F_LOW) || (st_r == F_HIGH);
	assign o_mem_addr = addr_r;
	assign vec.done   = (st_r == F_DONE);
	assign vec.target = target_r;

	// table entry: low byte at pointer, high byte at pointer + 1
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st_r     <= F_IDLE;
			low_r    <= `BYTE_ZERO;
			addr_r   <= `ADDR_ZERO;
			target_r <= `ADDR_ZERO;
		end else begin
			unique case (st_r)
				F_IDLE: begin
					if (vec.req) begin
						addr_r <= vec.ptr;
						st_r   <= F_LOW;
					end
				end
				F_LOW: begin
					if (i_mem_ack) begin
						low_r  <= i_mem_data;
						addr_r <= addr_r + `ADDR_ONE;
						st_r   <= F_HIGH;
					end
				end
				F_HIGH: begin
					if (i_mem_ack) begin
						target_r <= {i_mem_data, low_r};
						st_r     <= F_DONE;
					end
				end
				F_DONE: st_r <= F_IDLE;
			endcase
		end
	end
endmodule // irq_vec_fetch

/* tb/irq_accept_sva.sv */
// assertions on the acceptance ports
module irq_accept_sva
	import irq_accept_pkg::*;
(
	input wire logic  i_clk,
	input wire logic  i_rst_n,
	input wire logic  i_boundary,
	input wire logic  i_enable_irq_instruction,
	input wire logic  i_disable_irq_instruction,
	input wire logic  o_irq_acknowledge_n,
	input wire logic  o_mem_rd,
	input wire logic  o_redirect,
	input wire addr_t o_redirect_addr,
	input wire logic  o_discard_fetch,
	input wire logic  o_busy,
	input wire logic  o_primary_enable_flag,
	input wire logic  o_shadow_enable_flag
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	wire logic ack = !o_irq_acknowledge_n;
	wire logic pf  = o_primary_enable_flag;
	wire logic sf  = o_shadow_enable_flag;
	wire logic ei  = i_enable_irq_instruction;
	// ==========
	// properties
	property p_nmi_addr; o_discard_fetch |-> o_redirect && o_redirect_addr == 16'h0066; endproperty
	property p_ack_one; ack |=> !ack; endproperty
	property p_ack_gate; $rose(ack) |-> $past(pf); endproperty
	property p_take_clr; ack |-> !pf && !sf && o_busy; endproperty
	property p_ei; ei && !i_boundary |=> pf && sf; endproperty
	property p_di; i_disable_irq_instruction && !ei && !i_boundary |=> !pf && !sf; endproperty
	property p_nmi_pf; $rose(o_discard_fetch) |-> !pf; endproperty
	property p_ei_hold; ei && i_boundary ##1 !i_boundary ##1 i_boundary |=> !ack; endproperty
	a_nmi_addr: assert property (p_nmi_addr) else $error("nmi redirect wrong");
	a_ack_one: assert property (p_ack_one) else $error("ack too long");
	a_ack_gate: assert property (p_ack_gate) else $error("take while disabled");
	a_take_clr: assert property (p_take_clr) else $error("flags kept at take");
	a_ei: assert property (p_ei) else $error("enable failed");
	a_di: assert property (p_di) else $error("disable failed");
	a_nmi_pf: assert property (p_nmi_pf) else $error("primary kept at nmi");
	a_ei_hold: assert property (p_ei_hold) else $error("take too early");
	c_nmi: cover property (o_discard_fetch);
	c_table: cover property (o_mem_rd);
	c_take: cover property (ack);
endmodule // irq_accept_sva

/* tb/irq_ctrl_model.sv */
// far side: vectoring controller and service table memory
module irq_ctrl_model
	import irq_accept_pkg::*;
(
	input  wire logic  i_clk,
	input  wire logic  i_ack_n,
	input  wire byte_t i_vec,
	input  wire logic  i_slow,
	input  wire logic  i_mem_rd,
	input  wire addr_t i_mem_addr,
	output byte_t      o_vec,
	output logic       o_mem_ack,
	output byte_t      o_mem_data
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] wait_r = 2'h0;
	byte_t      entry;
	initial o_mem_ack = 1'b0;
	assign entry      = i_mem_addr[7:0] + 8'h11;
	// vector valid only during acknowledge
	assign o_vec      = i_ack_n ? ~i_vec : i_vec;
	assign o_mem_data = o_mem_ack ? entry : ~entry;
	always @(posedge i_clk) begin
		o_mem_ack <= i_mem_rd && !o_mem_ack && wait_r == 2'h0;
		if (o_mem_ack)
			wait_r <= i_slow ? 2'h3 : 2'h0;
		else if (wait_r != 2'h0)
			wait_r <= wait_r - 2'h1;
	end
endmodule // irq_ctrl_model

/* tb/tb_irq_accept.sv */
// testbench for the interrupt acceptance logic
module tb_irq_accept;
	timeunit 1ns;
	timeprecision 1ps;
	import irq_accept_pkg::*;
	logic  i_clk = 0, i_rst_n = 0, i_boundary = 0, i_irq_n = 1, slow = 0, d;
	logic  i_enable_irq_instruction = 0, i_disable_irq_instruction = 0;
	logic  i_restore_enable = 0, i_return_done = 0;
	logic  [7:0] i_nmi_src = 8'h00;
	logic  [2:0] i_nmi_sel = 3'h0;
	irq_mode_e i_irq_mode = IRQ_MODE_0;
	byte_t i_vector_page = 8'h80, vec = 8'h2b, i_vector_low, i_mem_data;
	addr_t i_next_pc = 16'h1230, o_mem_addr, o_redirect_addr, o_resume_addr, exp;
	logic  o_irq_acknowledge_n, o_mem_rd, i_mem_ack, o_redirect, o_discard_fetch, o_resume;
	logic  o_busy, o_primary_enable_flag, o_shadow_enable_flag;
	int    error_cnt = 0, compares = 0, cyc = 0;
	logic  [15:0] flags;
	assign flags = {14'h0000, o_primary_enable_flag, o_shadow_enable_flag};
	irq_accept irq_accept_inst (.i_clk(i_clk), .i_rst_n(i_rst_n),
		.i_nmi_src(i_nmi_src), .i_nmi_sel(i_nmi_sel), .i_irq_n(i_irq_n),
		.i_boundary(i_boundary), .i_next_pc(i_next_pc),
		.i_enable_irq_instruction(i_enable_irq_instruction),
		.i_disable_irq_instruction(i_disable_irq_instruction),
		.i_restore_enable(i_restore_enable), .i_return_done(i_return_done),
		.i_irq_mode(i_irq_mode), .i_vector_page(i_vector_page),
		.o_irq_acknowledge_n(o_irq_acknowledge_n), .i_vector_low(i_vector_low),
		.o_mem_rd(o_mem_rd), .o_mem_addr(o_mem_addr), .i_mem_ack(i_mem_ack),
		.i_mem_data(i_mem_data), .o_redirect(o_redirect),
		.o_redirect_addr(o_redirect_addr), .o_discard_fetch(o_discard_fetch),
		.o_resume(o_resume), .o_resume_addr(o_resume_addr), .o_busy(o_busy),
		.o_primary_enable_flag(o_primary_enable_flag),
		.o_shadow_enable_flag(o_shadow_enable_flag));
	irq_ctrl_model irq_ctrl_model_inst (.i_clk(i_clk), .i_ack_n(o_irq_acknowledge_n),
		.i_vec(vec), .i_slow(slow), .i_mem_rd(o_mem_rd), .i_mem_addr(o_mem_addr),
		.o_vec(i_vector_low), .o_mem_ack(i_mem_ack), .o_mem_data(i_mem_data));
	always #12.5 i_clk = ~i_clk;
	always @(posedge i_clk) begin
		cyc++;
		if (cyc == 3000) begin
			error_cnt++;
			end_sim();
		end
	end
	// ==========
	// tasks
	task automatic end_sim();
		if (error_cnt == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		compares++;
		if (g !== e) begin
			error_cnt++;
			$display("unexpected %s: expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic op(input logic b, e, s, r);
		@(posedge i_clk) #2;
		{i_boundary, i_enable_irq_instruction, i_disable_irq_instruction,
			i_restore_enable} = {b, e, s, r};
		@(posedge i_clk) #2;
		{i_boundary, i_enable_irq_instruction, i_disable_irq_instruction,
			i_restore_enable} = 4'h0;
	endtask
	task automatic wait_red();
		for (int k = 0; k < 40 && o_redirect !== 1'b1; k++) @(posedge i_clk) #2;
		d = o_discard_fetch;
		chk("redirect", 16'h0001, {15'h0000, o_redirect});
	endtask
	// ==========
	// sequence
	initial begin
		repeat (12) @(posedge i_clk);
		#2 i_rst_n = 1'b1;
		chk("flags_rst", 16'h0000, flags);
		i_irq_n = 1'b0;
		op(1, 0, 0, 0);
		chk("ack_off", 16'h0001, {15'h0000, o_irq_acknowledge_n});
		for (int m = 0; m < 4; m++) begin
			i_irq_mode = irq_mode_e'(m);
			i_next_pc = 16'h1230 + 16'(m);
			slow = (m == 2);
			op(1, 1, 0, 0);
			chk("flags_ei", 16'h0003, flags);
			op(1, 0, 0, 0);
			chk("ack_hold", 16'h0001, {15'h0000, o_irq_acknowledge_n});
			op(1, 0, 0, 0);
			chk("ack_take", 16'h0000, {15'h0000, o_irq_acknowledge_n});
			chk("busy", 16'h0001, {15'h0000, o_busy});
			chk("flags_take", 16'h0000, flags);
			// later pc values must not leak into the saved return point
			i_next_pc = 16'h0fff;
			exp = (m == 1) ? 16'h0038 : (m == 2) ? 16'h3c3b : {8'h00, vec & 8'h38};
			wait_red();
			chk("target", exp, o_redirect_addr);
			chk("idle", 16'h0000, {15'h0000, o_busy});
			exp = 16'h1230 + 16'(m);
			@(posedge i_clk) #2 i_return_done = 1'b1;
			@(posedge i_clk) #2 i_return_done = 1'b0;
			for (int k = 0; k < 8 && o_resume !== 1'b1; k++) @(posedge i_clk) #2;
			chk("resume", exp, (o_resume === 1'b1) ? o_resume_addr : ~exp);
		end
		op(0, 1, 0, 0);
		// clears the enable hold so the maskable line competes with the nmi
		op(1, 0, 0, 0);
		i_nmi_sel = 3'h5;
		@(posedge i_clk) #2 i_nmi_src = 8'h2f;
		op(1, 0, 0, 0);
		wait_red();
		chk("nmi_addr", 16'h0066, o_redirect_addr);
		chk("nmi_first", 16'h0001, {15'h0000, o_irq_acknowledge_n});
		chk("discard", 16'h0001, {15'h0000, d});
		chk("flags_nmi", 16'h0001, flags);
		op(0, 0, 0, 1);
		chk("flags_rest", 16'h0003, flags);
		op(0, 0, 1, 0);
		chk("flags_di", 16'h0000, flags);
		op(0, 1, 0, 0);
		i_nmi_src = 8'hfb;
		i_nmi_sel = 3'h2;
		@(posedge i_clk) #2 i_rst_n = 1'b0;
		@(posedge i_clk) #2 i_rst_n = 1'b1;
		chk("flags_rerst", 16'h0000, flags);
		op(1, 0, 0, 0);
		chk("sel_off", 16'h0000, {15'h0000, o_redirect});
		@(posedge i_clk) #2 i_nmi_src = 8'h04;
		op(1, 0, 0, 0);
		wait_red();
		chk("nmi_off", 16'h0066, o_redirect_addr);
		chk("sel_line", 16'h0001, {15'h0000, d});
		end_sim();
	end
endmodule // tb_irq_accept

bind irq_accept irq_accept_sva irq_accept_sva_inst (
	.i_clk                     (i_clk),
	.i_rst_n                   (i_rst_n),
	.i_boundary                (i_boundary),
	.i_enable_irq_instruction  (i_enable_irq_instruction),
	.i_disable_irq_instruction (i_disable_irq_instruction),
	.o_irq_acknowledge_n       (o_irq_acknowledge_n),
	.o_mem_rd                  (o_mem_rd),
	.o_redirect                (o_redirect),
	.o_redirect_addr           (o_redirect_addr),
	.o_discard_fetch           (o_discard_fetch),
	.o_busy                    (o_busy),
	.o_primary_enable_flag     (o_primary_enable_flag),
	.o_shadow_enable_flag      (o_shadow_enable_flag)
);
